// file: core/async_edge_catch.sv
/*
 Edge catcher for one low pin: the pin itself clocks a capture flop so
 that an edge is held while the core clock is stopped. Assumes the pin
 is clean enough to serve as a clock and the core clears via clr_pulse.
*/
`timescale 1ns/1ps
module async_edge_catch (
	// Pin and setup
	input wire logic pin,
	input wire logic rise_sel,
	// Core domain
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic clr_pulse,
	output logic caught
);
	logic pin_sel;
	logic cap_r;
	logic clr_r;
	logic rise_r;
	logic sync1_r;
	logic sync2_r;
	// Invert for falling edges so one capture flop serves both senses
	assign pin_sel = rise_r ? pin : ~pin;
	// Capture runs on the pin, no core clock needed
	always_ff @(posedge pin_sel or posedge clr_r) begin
		if (clr_r)
			cap_r <= 1'b0;
		else
			cap_r <= 1'b1;
	end
	// Two-flop crossing into the core domain
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			clr_r <= 1'b1;
		end else begin
			sync1_r <= cap_r;
			sync2_r <= sync1_r;
			// Stay clear across a sense flip, else the inversion looks like an edge
			clr_r <= clr_pulse || (rise_sel != rise_r);
		end
	end
	// Sense direction only moves while the capture flop is already held clear
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			rise_r <= 1'b0;
		else if (clr_r)
			rise_r <= rise_sel;
	end
	assign caught = sync2_r;
endmodule : async_edge_catch

// file: core/ext_irq_ctrl.sv
/*
 External request sensing, flag/mask registers and vector placement
 control. Assumes an I/O port access bus from the core (io_*), the
 data-space access bus (ds_*), and one core clock mclk at 40 MHz.
*/
`timescale 1ns/1ps
`include "ext_irq_params.svh"
module ext_irq_ctrl #(
	parameter int NPINS = 8
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// I/O port access
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [5:0] io_addr,
	input wire ext_irq_pkg::byte_t io_wdata,
	// Data-space access
	input wire logic ds_wr,
	input wire logic ds_rd,
	input wire logic [7:0] ds_addr,
	input wire ext_irq_pkg::byte_t ds_wdata,
	output ext_irq_pkg::byte_t rdata,
	// Core status
	input wire logic global_ie,
	input wire logic instr_done,
	input wire logic run_in_boot,
	input wire logic legacy_mode,
	input wire logic [NPINS-1:0] irq_ack,
	// Fuses and lock bits
	input wire logic app_lock_bit,
	input wire logic boot_lock_bit,
	input wire logic [15:0] boot_base,
	// Sleep and wake
	input wire logic power_down,
	input wire logic wdog_tick,
	input wire logic startup_done,
	output logic wake_req,
	// Pins
	input wire logic [NPINS-1:0] external_request_pins,
	// To the core
	output logic [NPINS-1:0] irq_req,
	output logic irq_block,
	output logic [15:0] vector_base
);
	import ext_irq_pkg::*;

	logic vector_table_select_r;
	logic vector_change_unlock_r;
	logic [2:0] unlock_cnt_r;
	logic block_tail_r;
	byte_t low_pins_sense_config_r;
	byte_t high_pins_sense_config_r;
	byte_t pin_irq_mask_r;
	byte_t pin_request_flags_r;
	byte_t pin_s1_r;
	byte_t pin_s2_r;
	byte_t pin_prev_r;
	logic [NPINS-1:0] edge_hit;
	logic [NPINS-1:0] level_on;
	logic [3:0] async_caught;
	logic [3:0] async_clr;
	logic wr_ctrl, wr_flags, wr_mask, wr_hi, wr_lo;
	logic rd_any;
	byte_t wdata;
	byte_t rdata_nxt;
	wake_e wake_r;

	////////////////////////////////////////////////////////////////////
	// Register decode

	// Map a data-space address onto an I/O offset when in range
	function automatic logic ds_hits(input logic [7:0] a, input logic [7:0] io_ofs);
		ds_hits = (a == io_ofs + `DS_IO_DISP);
	endfunction : ds_hits

	// Map an I/O port offset onto a register
	function automatic logic io_hits(input logic [5:0] a, input logic [7:0] io_ofs);
		io_hits = ({2'b00, a} == io_ofs);
	endfunction : io_hits

	assign wdata = io_wr ? io_wdata : ds_wdata;
	assign wr_ctrl = (io_wr && io_hits(io_addr, `IO_OFS_CTRL))
		|| (ds_wr && ds_hits(ds_addr, `IO_OFS_CTRL));
	assign wr_flags = (io_wr && io_hits(io_addr, `IO_OFS_FLAGS))
		|| (ds_wr && ds_hits(ds_addr, `IO_OFS_FLAGS));
	assign wr_mask = (io_wr && io_hits(io_addr, `IO_OFS_MASK))
		|| (ds_wr && ds_hits(ds_addr, `IO_OFS_MASK));
	assign wr_hi = (io_wr && io_hits(io_addr, `IO_OFS_HISENSE))
		|| (ds_wr && ds_hits(ds_addr, `IO_OFS_HISENSE));
	// Extended space only, and hidden in legacy mode
	assign wr_lo = ds_wr && (ds_addr == `DS_OFS_LOSENSE) && !legacy_mode;
	assign rd_any = io_rd || ds_rd;

	// Read mux; unmapped addresses read zero
	always_comb begin
		rdata_nxt = 8'h00;
		if (io_rd) begin
			if (io_hits(io_addr, `IO_OFS_CTRL))
				rdata_nxt = {6'h00, vector_table_select_r, vector_change_unlock_r};
			else if (io_hits(io_addr, `IO_OFS_FLAGS))
				rdata_nxt = pin_request_flags_r;
			else if (io_hits(io_addr, `IO_OFS_MASK))
				rdata_nxt = pin_irq_mask_r;
			else if (io_hits(io_addr, `IO_OFS_HISENSE))
				rdata_nxt = high_pins_sense_config_r;
		end else if (ds_rd) begin
			if (ds_hits(ds_addr, `IO_OFS_CTRL))
				rdata_nxt = {6'h00, vector_table_select_r, vector_change_unlock_r};
			else if (ds_hits(ds_addr, `IO_OFS_FLAGS))
				rdata_nxt = pin_request_flags_r;
			else if (ds_hits(ds_addr, `IO_OFS_MASK))
				rdata_nxt = pin_irq_mask_r;
			else if (ds_hits(ds_addr, `IO_OFS_HISENSE))
				rdata_nxt = high_pins_sense_config_r;
			else if (ds_addr == `DS_OFS_LOSENSE && !legacy_mode)
				rdata_nxt = low_pins_sense_config_r;
		end
	end

	// Read data registered; held between reads
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			rdata <= 8'h00;
		else if (rd_any)
			rdata <= rdata_nxt;
	end

	////////////////////////////////////////////////////////////////////
	// Vector placement and timed unlock

	// Unlock counts down; a select write in the window ends it early
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			vector_table_select_r <= 1'b0;
			vector_change_unlock_r <= 1'b0;
			unlock_cnt_r <= 3'd0;
		end else if (wr_ctrl && vector_change_unlock_r
			&& !wdata[`CTRL_UNLOCK_BIT]) begin
			vector_table_select_r <= wdata[`CTRL_SEL_BIT];
			vector_change_unlock_r <= 1'b0;
			unlock_cnt_r <= 3'd0;
		end else if (wr_ctrl && wdata[`CTRL_UNLOCK_BIT]) begin
			vector_change_unlock_r <= 1'b1;
			unlock_cnt_r <= `UNLOCK_CYCLES;
		end else if (unlock_cnt_r != 3'd0) begin
			unlock_cnt_r <= unlock_cnt_r - 3'd1;
			if (unlock_cnt_r == 3'd1)
				vector_change_unlock_r <= 1'b0;
		end
	end

	// Keep blocking until the instruction after the select write ends
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			block_tail_r <= 1'b0;
		else if (wr_ctrl && vector_change_unlock_r && !wdata[`CTRL_UNLOCK_BIT])
			block_tail_r <= 1'b1;
		else if (instr_done)
			block_tail_r <= 1'b0;
	end

	// Blocking and lock suppression; global_ie itself is never written
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			irq_block <= 1'b0;
			vector_base <= 16'h0000;
		end else begin
			irq_block <= vector_change_unlock_r || block_tail_r
				|| (wr_ctrl && wdata[`CTRL_UNLOCK_BIT])
				|| (vector_table_select_r && app_lock_bit && !run_in_boot)
				|| (!vector_table_select_r && boot_lock_bit && run_in_boot);
			vector_base <= vector_table_select_r ? boot_base : 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Sense, mask and pin sampling

	// Plain read/write configuration
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			low_pins_sense_config_r <= `RST_SENSE;
			high_pins_sense_config_r <= `RST_SENSE;
			pin_irq_mask_r <= `RST_MASK;
		end else begin
			if (wr_lo)
				low_pins_sense_config_r <= wdata;
			if (wr_hi)
				high_pins_sense_config_r <= wdata;
			if (wr_mask)
				pin_irq_mask_r <= wdata;
		end
	end

	// Pins read straight from the pad, even when driven as outputs
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1_r <= 8'hFF;
			pin_s2_r <= 8'hFF;
			pin_prev_r <= 8'hFF;
		end else begin
			pin_s1_r <= external_request_pins;
			pin_s2_r <= pin_s1_r;
			pin_prev_r <= pin_s2_r;
		end
	end

	// Per-pin detection: async catchers low, sampled compare high
	genvar gi;
	generate
		for (gi = 0; gi < NPINS; gi++) begin : g_pin
			sense_e sel;
			if (gi < 4) begin : g_async
				assign sel = sense_e'(low_pins_sense_config_r[2*gi +: 2]);
				assign async_clr[gi] = (sel == SENSE_LOW) || (sel == SENSE_RSVD)
					|| async_caught[gi];
				async_edge_catch u_catch (
					.pin(external_request_pins[gi]),
					.rise_sel(sel[0]),
					.mclk(mclk),
					.rst_b(rst_b),
					.clr_pulse(async_clr[gi]),
					.caught(async_caught[gi])
				);
				assign edge_hit[gi] = async_caught[gi] && sel[1];
			end else begin : g_sync
				assign sel = sense_e'(high_pins_sense_config_r[2*(gi-4) +: 2]);
				assign edge_hit[gi] = (sel == SENSE_FALL && pin_prev_r[gi] && !pin_s2_r[gi])
					|| (sel == SENSE_RISE && !pin_prev_r[gi] && pin_s2_r[gi]);
			end
			assign level_on[gi] = (sel == SENSE_LOW) && !pin_s2_r[gi];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Flags and request outputs

	// Set wins over clear; level-mode pins hold their flag at zero
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			pin_request_flags_r <= `RST_FLAGS;
		else begin
			for (int i = 0; i < NPINS; i++) begin
				if (i < 4 ? low_pins_sense_config_r[2*i +: 2] == SENSE_LOW
					: high_pins_sense_config_r[2*(i-4) +: 2] == SENSE_LOW)
					pin_request_flags_r[i] <= 1'b0;
				else if (edge_hit[i])
					pin_request_flags_r[i] <= 1'b1;
				else if (irq_ack[i] || (wr_flags && wdata[i]))
					pin_request_flags_r[i] <= 1'b0;
			end
		end
	end

	// Requests need global enable, mask and no suppression
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			irq_req <= '0;
		else
			irq_req <= (pin_request_flags_r | level_on) & pin_irq_mask_r
				& {NPINS{global_ie && !irq_block}};
	end

	////////////////////////////////////////////////////////////////////
	// Power-down level wake

	// Two watchdog samples with the level present; wake held until start-up end or power-down exit
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wake_r <= WAKE_IDLE;
			wake_req <= 1'b0;
		end else begin
			case (wake_r)
				WAKE_IDLE: begin
					wake_req <= 1'b0;
					if (power_down && wdog_tick && |(level_on & pin_irq_mask_r))
						wake_r <= WAKE_ONE;
				end
				WAKE_ONE: begin
					// Leaving power-down between the samples abandons the wake
					if (!power_down)
						wake_r <= WAKE_IDLE;
					else if (wdog_tick) begin
						if (|(level_on & pin_irq_mask_r)) begin
							wake_r <= WAKE_HELD;
							wake_req <= 1'b1;
						end else
							wake_r <= WAKE_IDLE;
					end
				end
				WAKE_HELD: begin
					// Wake stands even if the level goes; the request path then
					// sees no level, so no interrupt follows
					if (startup_done || !power_down) begin
						wake_r <= WAKE_IDLE;
						wake_req <= 1'b0;
					end
				end
				default: wake_r <= WAKE_IDLE;
			endcase
		end
	end
endmodule : ext_irq_ctrl

// file: pkg/ext_irq_params.svh
/*
 Register offsets, reset values and timing counts for the external
 request and vector placement logic. Assumes a 40 MHz core clock.
*/
`ifndef EXT_IRQ_PARAMS_SVH
`define EXT_IRQ_PARAMS_SVH
// I/O offsets, the data-space low-sense address and the data-space displacement
`define IO_OFS_CTRL 8'h35
`define IO_OFS_FLAGS 8'h38
`define IO_OFS_MASK 8'h39
`define IO_OFS_HISENSE 8'h3A
`define DS_OFS_LOSENSE 8'h6A
`define DS_IO_DISP 8'h20
// Reset values
`define RST_CTRL 8'h00
`define RST_SENSE 8'h00
`define RST_MASK 8'h00
`define RST_FLAGS 8'h00
// Control register bit positions
`define CTRL_SEL_BIT 1
`define CTRL_UNLOCK_BIT 0
// Unlock window in cycles
`define UNLOCK_CYCLES 3'd4
// Wake sampler: watchdog period 1000 ns, core period 25 ns
`define WDOG_PERIOD_NS 1000
`define CLK_PERIOD_NS 25
`define WDOG_TICK_CYCLES (`WDOG_PERIOD_NS / `CLK_PERIOD_NS)
`define MIN_ASYNC_PULSE_NS 50
`endif

// file: pkg/ext_irq_pkg.sv
/*
 Types shared by the external request logic.
 Assumes the params header is compiled alongside.
*/
package ext_irq_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic [1:0] {
		SENSE_LOW = 2'b00,
		SENSE_RSVD = 2'b01,
		SENSE_FALL = 2'b10,
		SENSE_RISE = 2'b11
	} sense_e;
	typedef enum logic [1:0] {
		WAKE_IDLE = 2'b00,
		WAKE_ONE = 2'b01,
		WAKE_HELD = 2'b10
	} wake_e;
endpackage : ext_irq_pkg

// file: tb/ext_irq_and_vector_select_assertions.sv
/*
 Port checker for the external request and vector placement block.
 Assumes the bench holds boot_base steady and pulses instr_done.
*/
`timescale 1ns/1ps
module ext_irq_chk #(
	parameter int NPINS = 8
) (
	// Watched ports
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [5:0] io_addr,
	input wire ext_irq_pkg::byte_t io_wdata,
	input wire logic ds_rd,
	input wire ext_irq_pkg::byte_t rdata,
	input wire logic global_ie,
	input wire logic run_in_boot,
	input wire logic app_lock_bit,
	input wire logic boot_lock_bit,
	input wire logic [15:0] boot_base,
	input wire logic power_down,
	input wire logic wake_req,
	input wire logic [NPINS-1:0] irq_req,
	input wire logic irq_block,
	input wire logic [15:0] vector_base
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////////////
	// Vector placement, unlock blocking and global enable
	property p_vec; vector_base == 16'h0 || vector_base == boot_base; endproperty
	a_vec: assert property (p_vec) else $error("vector base neither zero nor boot");
	property p_unl; io_wr && io_addr == 6'h35 && io_wdata == 8'h01 |-> ##[1:2] irq_block;
	endproperty
	a_unl: assert property (p_unl) else $error("unlock did not block");
	property p_blk; $past(irq_block) |-> irq_req == '0; endproperty
	a_blk: assert property (p_blk) else $error("request while blocked");
	property p_rel; $rose(irq_block) && !app_lock_bit && !boot_lock_bit |-> ##[1:24] !irq_block;
	endproperty
	a_rel: assert property (p_rel) else $error("block never released");
	property p_lock; (app_lock_bit && vector_base != 16'h0 && !run_in_boot) [*2] |-> irq_block;
	endproperty
	a_lock: assert property (p_lock) else $error("lock did not suppress");
	property p_gie; !$past(global_ie) |-> irq_req == '0; endproperty
	a_gie: assert property (p_gie) else $error("request without global enable");
	////////////////////////////////////////////////////////////////////////
	// Read data and wake
	property p_rd; !$past(io_rd) && !$past(ds_rd) |-> $stable(rdata); endproperty
	a_rd: assert property (p_rd) else $error("read data moved without a read");
	property p_unm; io_rd && !ds_rd && io_addr == 6'h01 |=> rdata == 8'h00; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	property p_wake; !power_down [*2] |-> !wake_req; endproperty
	a_wake: assert property (p_wake) else $error("wake outside power-down");
	c_req: cover property (irq_req != '0);
	c_blk: cover property ($rose(irq_block));
	c_wake: cover property (wake_req);
endmodule : ext_irq_chk
bind ext_irq_ctrl ext_irq_chk #(.NPINS(NPINS)) u_chk (.mclk(mclk), .rst_b(rst_b),
	.io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata), .ds_rd(ds_rd),
	.rdata(rdata), .global_ie(global_ie), .run_in_boot(run_in_boot),
	.app_lock_bit(app_lock_bit), .boot_lock_bit(boot_lock_bit), .boot_base(boot_base),
	.power_down(power_down), .wake_req(wake_req), .irq_req(irq_req),
	.irq_block(irq_block), .vector_base(vector_base));

// file: tb/ext_pin_model.sv
/*
 Off-chip sources on the eight request pads.
 Assumes pads are pulled up, so they idle high.
*/
`timescale 1ns/1ps
module ext_pin_model (
	// Timing
	input wire logic mclk,
	// Pads
	output logic [7:0] pins
);
	// Pull-up level until a source drives
	initial pins = 8'hFF;
	// Holds far longer than one clock, so the sampled pins catch it too
	task automatic hold(input int p, input logic lvl);
		@(negedge mclk) pins[p] = lvl;
	endtask : hold
endmodule : ext_pin_model

// file: tb/test_ext_irq_and_vector_select.sv
/*
 Self-checking bench for the request controller.
 Assumes the pin model stands in for the off-chip sources.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
	$display("BAD %0t got %h exp %h", $time, (a), (b)); end end
module test_ext_irq_and_vector_select;
	import ext_irq_pkg::*;
	logic mclk = 0, rst_b = 0, io_wr, io_rd, ds_wr, ds_rd, global_ie, instr_done;
	logic run_in_boot, legacy_mode, app_lock_bit, boot_lock_bit, power_down;
	logic wdog_tick, startup_done, wake_req, irq_block, g, mk;
	logic [5:0] io_addr;
	logic [7:0] ds_addr, irq_req, irq_ack, pins, ra[7];
	byte_t io_wdata, ds_wdata, rdata, q, d;
	logic [15:0] vector_base, boot_base = 16'hE000;
	int fails = 0, check_count = 0, seed = 32'hf1db7b7a, cyc = 0, i, p, m;
	ext_pin_model u_pins (.mclk(mclk), .pins(pins));
	ext_irq_ctrl u_dut (.mclk(mclk), .rst_b(rst_b), .io_wr(io_wr), .io_rd(io_rd),
		.io_addr(io_addr), .io_wdata(io_wdata), .ds_wr(ds_wr), .ds_rd(ds_rd),
		.ds_addr(ds_addr), .ds_wdata(ds_wdata), .rdata(rdata), .global_ie(global_ie),
		.instr_done(instr_done), .run_in_boot(run_in_boot), .legacy_mode(legacy_mode),
		.irq_ack(irq_ack), .app_lock_bit(app_lock_bit), .boot_lock_bit(boot_lock_bit),
		.boot_base(boot_base), .power_down(power_down), .wdog_tick(wdog_tick),
		.startup_done(startup_done), .wake_req(wake_req), .external_request_pins(pins),
		.irq_req(irq_req), .irq_block(irq_block), .vector_base(vector_base));
	////////////////////////////////////////////////////////////////////////
	// Clock, instruction ends every fourth cycle
	always #12.5 mclk = ~mclk;
	always @(negedge mclk) begin
		cyc <= cyc + 1;
		instr_done <= (cyc % 4) == 0;
	end
	// Edge mode and direction give the flag
	function automatic logic exp_flag(input int m, input int low);
		return (low != 0) ? (m == 2) : (m == 3);
	endfunction : exp_flag
	// One strobe cycle, then an extra cycle so read data has landed
	task automatic bus(input int ds, input int w, input logic [7:0] a, input byte_t wd);
		@(negedge mclk);
		if (ds != 0) begin
			{ds_wr, ds_rd, ds_addr, ds_wdata} = {w != 0, w == 0, a, wd};
		end else begin
			{io_wr, io_rd, io_addr, io_wdata} = {w != 0, w == 0, a[5:0], wd};
		end
		@(negedge mclk) {io_wr, io_rd, ds_wr, ds_rd} = 4'h0;
		@(negedge mclk) q = rdata;
	endtask : bus
	task automatic finish_test;
		$display("fails %0d check_count %0d", fails, check_count);
		if (fails == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	////////////////////////////////////////////////////////////////////////
	// Watchdog
	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		finish_test();
	end
	// Main sequence
	initial begin
		{io_wr, io_rd, ds_wr, ds_rd, global_ie, run_in_boot, legacy_mode} = 7'h0;
		{app_lock_bit, boot_lock_bit, power_down, wdog_tick, startup_done} = 5'h0;
		{io_addr, io_wdata, ds_addr, ds_wdata, irq_ack} = '0;
		ra = '{8'h35, 8'h38, 8'h39, 8'h3A, 8'h01, 8'h6A, 8'h55};
		repeat (10) @(negedge mclk);
		rst_b = 1;
		for (i = 0; i < 7; i++) begin
			bus(i > 4, 0, ra[i], 8'h00);
			`CHK(q, 8'h00)
		end
		d = 8'($random(seed));
		bus(1, 1, 8'h5A, d);
		bus(0, 0, 8'h3A, 8'h00);
		`CHK(q, d)
		bus(1, 1, 8'h6A, d);
		bus(1, 0, 8'h6A, 8'h00);
		`CHK(q, d)
		legacy_mode = 1;
		bus(1, 0, 8'h6A, 8'h00);
		`CHK(q, 8'h00)
		legacy_mode = 0;
		bus(0, 1, 8'h3A, 8'h00);
		// Unlock then select back to back, then a late select that must be ignored
		bus(0, 1, 8'h35, 8'h01);
		bus(0, 1, 8'h35, 8'h02);
		repeat (4) @(negedge mclk);
		`CHK(vector_base, boot_base)
		bus(0, 1, 8'h35, 8'h01);
		repeat (6) @(negedge mclk);
		bus(0, 0, 8'h35, 8'h00);
		`CHK(q, 8'h02)
		bus(0, 1, 8'h35, 8'h00);
		repeat (4) @(negedge mclk);
		`CHK(vector_base, boot_base)
		app_lock_bit = 1;
		repeat (3) @(negedge mclk);
		`CHK(irq_block, 1'b1)
		app_lock_bit = 0;
		bus(0, 1, 8'h35, 8'h01);
		bus(0, 1, 8'h35, 8'h00);
		repeat (8) @(negedge mclk);
		`CHK(vector_base, 16'h0000)
		// Vectors in the application area, running from boot, boot lock set
		{boot_lock_bit, run_in_boot} = 2'b11;
		repeat (3) @(negedge mclk);
		`CHK(irq_block, 1'b1)
		{boot_lock_bit, run_in_boot} = 2'b00;
		// Every sense code on every pin, with random mask and global enable
		for (p = 0; p < 8; p++) begin
			for (m = 0; m < 4; m++) begin
				mk = 1'($random(seed));
				g = 1'($random(seed));
				global_ie = g;
				bus(0, 1, 8'h39, 8'h00);
				bus(p < 4, 1, (p < 4) ? 8'h6A : 8'h3A, 8'(m) << (2 * (p % 4)));
				bus(0, 1, 8'h38, 8'h01 << p);
				bus(1, 1, 8'h59, 8'(mk) << p);
				u_pins.hold(p, 1'b0);
				repeat (6) @(negedge mclk);
				bus(0, 0, 8'h38, 8'h00);
				`CHK(q[p], exp_flag(m, 1))
				`CHK(irq_req[p], (exp_flag(m, 1) | (m == 0)) & mk & g)
				bus(0, 1, 8'h38, 8'h01 << p);
				u_pins.hold(p, 1'b1);
				repeat (6) @(negedge mclk);
				`CHK(irq_req[p], exp_flag(m, 0) & mk & g)
				@(negedge mclk) irq_ack[p] = 1'b1;
				@(negedge mclk) irq_ack[p] = 1'b0;
				bus(0, 0, 8'h38, 8'h00);
				`CHK(q[p], 1'b0)
			end
		end
		// Level wake from power-down, held across two watchdog ticks
		bus(0, 1, 8'h39, 8'h01);
		bus(1, 1, 8'h6A, 8'h00);
		power_down = 1;
		u_pins.hold(0, 1'b0);
		repeat (2) begin
			repeat (8) @(negedge mclk);
			wdog_tick = 1;
			@(negedge mclk) wdog_tick = 0;
		end
		repeat (4) @(negedge mclk);
		`CHK(wake_req, 1'b1)
		startup_done = 1;
		@(negedge mclk) {startup_done, power_down} = 2'b00;
		u_pins.hold(0, 1'b1);
		repeat (4) @(negedge mclk);
		finish_test();
	end
endmodule : test_ext_irq_and_vector_select
